/* File: hw/pmc_top.sv */
// Paging message checker: checksum, null stripping, fragment and number tracking.
// Assumes a front end that gives one header, then the fragment's codewords.
module pmc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hdr_valid_i,
  input wire pmc_pkg::pmc_hdr_t hdr_i,
  output logic hdr_ready_o,
  input wire logic cw_valid_i,
  input wire logic [pmc_pkg::INFO_W-1:0] cw_info_i,
  input wire logic cw_last_i,
  output logic cw_ready_o,
  output logic char_valid_o,
  output logic [pmc_pkg::CHAR_W-1:0] char_o,
  output logic [1:0] char_mode_o,
  output logic char_aligned_o,
  output pmc_pkg::pmc_res_t res_o,
  output logic irq_o
);
  typedef enum logic [1:0] {S_IDLE, S_WORDS, S_CHARS, S_FINISH} pmc_state_t;

  pmc_state_t state_q;
  pmc_pkg::pmc_hdr_t hdr_q;
  logic [31:0] ctrl_q;
  logic [pmc_pkg::ST_W-1:0] stat_q;
  logic [pmc_pkg::ST_W-1:0] mask_q;
  logic [pmc_pkg::ST_W-1:0] ev;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic [31:0] dat_q;
  logic ack_q;
  logic wr;
  logic en;
  logic [5:0] roll;
  logic hdr_fire;
  logic cw_fire;
  logic [pmc_pkg::INFO_W-1:0] word_q;
  logic last_q;
  logic [1:0] idx_q;
  logic [pmc_pkg::CSUM_W-1:0] csum;
  logic csum_err;
  logic null_err;
  logic [5:0] last_num_q [pmc_pkg::SLOTS];
  logic [pmc_pkg::SLOTS-1:0] seen_q;
  logic [pmc_pkg::SLOTS-1:0] prog_q;
  logic [5:0] prog_num_q [pmc_pkg::SLOTS];
  logic [1:0] prog_frag_q [pmc_pkg::SLOTS];
  logic first;
  logic [5:0] exp_num;
  logic [1:0] exp_frag;
  logic miss_msg;
  logic miss_frag;
  logic [1:0] eff_mode;
  logic [pmc_pkg::CHAR_W-1:0] cur_char;
  logic ch_valid;
  logic [5:0] hist_sel;

  // Register port.
  // A write lands at the edge where the master sees ack, while it still holds the request.
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign en = ctrl_q[pmc_pkg::CTRL_EN_BIT];
  assign roll = ctrl_q[pmc_pkg::CTRL_ROLL_LSB +: 6];

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      pmc_pkg::ADR_CTRL: rdata = ctrl_q;
      pmc_pkg::ADR_STAT: rdata = {27'h0, stat_q};
      pmc_pkg::ADR_MASK: rdata = {27'h0, mask_q};
      pmc_pkg::ADR_INFO: begin
        rdata[pmc_pkg::INFO_NUM_LSB +: 6] = hdr_q.msg_num;
        rdata[pmc_pkg::INFO_CSUM_LSB +: 8] = res_o.calc;
        rdata[pmc_pkg::INFO_MODE_LSB +: 2] = char_mode_o;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // One wait-free answer: ack follows the request edge by one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        dat_q <= wb_we_i ? 32'h0000_0000 : rdata;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= pmc_pkg::CTRL_RST;
      mask_q <= pmc_pkg::MASK_RST;
    end else if (wr && wb_adr_i == pmc_pkg::ADR_CTRL) begin
      ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask & pmc_pkg::CTRL_WMASK);
    end else if (wr && wb_adr_i == pmc_pkg::ADR_MASK) begin
      mask_q <= (mask_q & ~wmask[4:0]) | (wb_dat_i[4:0] & wmask[4:0]);
    end
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else if (wr && wb_adr_i == pmc_pkg::ADR_STAT) begin
      stat_q <= (stat_q & ~(wb_dat_i[4:0] & wmask[4:0])) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // Header checks against the per-address history.
  assign hdr_ready_o = state_q == S_IDLE && en;
  assign hdr_fire = hdr_valid_i && hdr_ready_o;
  assign first = hdr_i.frag_num == pmc_pkg::FRAG_FIRST;
  assign exp_num = (last_num_q[hdr_i.addr_slot] == roll) ? 6'h00
                 : last_num_q[hdr_i.addr_slot] + 6'h01;
  assign miss_msg = first && hdr_i.retrieve && seen_q[hdr_i.addr_slot]
                 && hdr_i.msg_num != exp_num;
  assign exp_frag = (prog_frag_q[hdr_i.addr_slot] == pmc_pkg::FRAG_FIRST
                 || prog_frag_q[hdr_i.addr_slot] == pmc_pkg::FRAG_LAST_CYC) ? 2'h0
                 : prog_frag_q[hdr_i.addr_slot] + 2'h1;
  assign miss_frag = !first && (!prog_q[hdr_i.addr_slot]
                 || prog_num_q[hdr_i.addr_slot] != hdr_i.msg_num
                 || hdr_i.frag_num != exp_frag);
  assign eff_mode = first ? pmc_pkg::CM_DEFAULT : hdr_i.char_mode;
  assign hist_sel = last_num_q[hdr_q.addr_slot];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_q <= '0;
      prog_q <= '0;
      for (int i = 0; i < pmc_pkg::SLOTS; i++) begin
        last_num_q[i] <= '0;
        prog_num_q[i] <= '0;
        prog_frag_q[i] <= '0;
      end
    end else if (hdr_fire) begin
      if (first && hdr_i.retrieve) begin
        last_num_q[hdr_i.addr_slot] <= hdr_i.msg_num;
        seen_q[hdr_i.addr_slot] <= 1'b1;
      end
      prog_q[hdr_i.addr_slot] <= hdr_i.cont;
      prog_num_q[hdr_i.addr_slot] <= hdr_i.msg_num;
      prog_frag_q[hdr_i.addr_slot] <= hdr_i.frag_num;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hdr_q <= '0;
      char_mode_o <= pmc_pkg::CM_DEFAULT;
      char_aligned_o <= 1'b1;
    end else if (hdr_fire) begin
      hdr_q <= hdr_i;
      char_mode_o <= eff_mode;
      char_aligned_o <= eff_mode != pmc_pkg::CM_NO_EF;
    end
  end

  // Fragment sequencer.
  assign cw_ready_o = state_q == S_WORDS;
  assign cw_fire = cw_valid_i && cw_ready_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      idx_q <= '0;
      word_q <= '0;
      last_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: if (hdr_fire) state_q <= S_WORDS;
        S_WORDS: begin
          if (cw_fire) begin
            word_q <= cw_info_i;
            last_q <= cw_last_i;
            idx_q <= '0;
            if (hdr_q.msg_type == pmc_pkg::MT_ALNUM) begin
              state_q <= S_CHARS;
            end else if (cw_last_i) begin
              state_q <= S_FINISH;
            end
          end
        end
        S_CHARS: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == 2'(pmc_pkg::CHARS_PER_CW - 1)) begin
            state_q <= last_q ? S_FINISH : S_WORDS;
          end
        end
        S_FINISH: state_q <= S_IDLE;
      endcase
    end
  end

  pmc_csum u_csum (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(hdr_fire),
    .add_i(cw_fire),
    .info_i(cw_info_i),
    .numeric_i(hdr_q.msg_type == pmc_pkg::MT_NUMERIC),
    .csum_o(csum)
  );

  assign csum_err = state_q == S_FINISH && csum != hdr_q.rx_csum;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_o <= '0;
    end else begin
      res_o.valid <= state_q == S_FINISH;
      if (state_q == S_FINISH) begin
        res_o.calc <= csum;
        res_o.ok <= !csum_err;
      end
    end
  end

  assign cur_char = word_q[idx_q * pmc_pkg::CHAR_W +: pmc_pkg::CHAR_W];
  assign ch_valid = state_q == S_CHARS;

  pmc_null_strip u_strip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(state_q == S_FINISH),
    .ch_valid_i(ch_valid),
    .ch_i(cur_char),
    .out_valid_o(char_valid_o),
    .out_o(char_o),
    .err_o(null_err)
  );

  always_comb begin
    ev = '0;
    ev[pmc_pkg::ST_CSUM] = csum_err;
    ev[pmc_pkg::ST_MISS_MSG] = hdr_fire && miss_msg;
    ev[pmc_pkg::ST_MISS_FRAG] = hdr_fire && miss_frag;
    ev[pmc_pkg::ST_NULL] = null_err;
    ev[pmc_pkg::ST_DONE] = state_q == S_FINISH;
  end

  sequence s_alnum_word;
    cw_fire && hdr_q.msg_type == pmc_pkg::MT_ALNUM;
  endsequence
  sequence s_three_chars;
    ch_valid [*3];
  endsequence

  a_chars_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    s_alnum_word |=> s_three_chars)
    else $error("codeword did not yield three characters");
  a_first_default: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_fire && first |=> char_mode_o == 2'h2 && char_aligned_o)
    else $error("first fragment not in default mode");
  a_csum_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_FINISH && csum != hdr_q.rx_csum |=> stat_q[0] && !res_o.ok)
    else $error("checksum mismatch not flagged");
  a_frag_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_fire && !first && !prog_q[hdr_i.addr_slot] |=> stat_q[2])
    else $error("orphan fragment not flagged");
  a_msg_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    hdr_fire && !hdr_i.retrieve |=> hist_sel == $past(last_num_q[hdr_i.addr_slot]))
    else $error("unnumbered message moved the number history");
  a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("bus answer not a single cycle after request");
endmodule // pmc_top

/* File: hw/pmc_pkg.sv */
// Shared constants and types of the paging message check block.
// Assumes one 40 MHz clock and a Wishbone classic register port.
package pmc_pkg;
  localparam int CLK_HZ = 40000000;
  // Register byte offsets.
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_MASK = 4'h8;
  localparam logic [3:0] ADR_INFO = 4'hc;
  // Control fields.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ROLL_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_3f01;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_3f01;
  // Status and mask bit positions.
  localparam int ST_CSUM = 0;
  localparam int ST_MISS_MSG = 1;
  localparam int ST_MISS_FRAG = 2;
  localparam int ST_NULL = 3;
  localparam int ST_DONE = 4;
  localparam int ST_W = 5;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;
  // Info register fields.
  localparam int INFO_NUM_LSB = 0;
  localparam int INFO_CSUM_LSB = 8;
  localparam int INFO_MODE_LSB = 16;
  // Message types.
  localparam logic [1:0] MT_SECURE = 2'h0;
  localparam logic [1:0] MT_NUMERIC = 2'h1;
  localparam logic [1:0] MT_HEX = 2'h2;
  localparam logic [1:0] MT_ALNUM = 2'h3;
  // Character-mode field codes.
  localparam logic [1:0] CM_NO_EF = 2'h0;
  localparam logic [1:0] CM_RSVD = 2'h1;
  localparam logic [1:0] CM_DEFAULT = 2'h2;
  localparam logic [1:0] CM_ALT = 2'h3;
  // Fragment numbering.
  localparam logic [1:0] FRAG_FIRST = 2'h3;
  localparam logic [1:0] FRAG_LAST_CYC = 2'h2;
  // Checksum shape.
  localparam int CSUM_W = 8;
  localparam int NUM_CSUM_W = 6;
  localparam int FOLD_SHIFT = 6;
  localparam int INFO_W = 21;
  localparam int CHAR_W = 7;
  localparam int CHARS_PER_CW = 3;
  localparam logic [CHAR_W-1:0] CHAR_NUL = 7'h00;
  localparam int SLOTS = 4;

  typedef struct packed {
    logic [1:0] msg_type;
    logic [1:0] addr_slot;
    logic [5:0] msg_num;
    logic [1:0] frag_num;
    logic [1:0] char_mode;
    logic retrieve;
    logic cont;
    logic [CSUM_W-1:0] rx_csum;
  } pmc_hdr_t;

  typedef struct packed {
    logic valid;
    logic [CSUM_W-1:0] calc;
    logic ok;
  } pmc_res_t;
endpackage

/* File: hw/pmc_csum.sv */
// Checksum accumulator over the 21 information bits of each codeword.
// Assumes clr_i at the start of every fragment and add_i once per codeword.
module pmc_csum (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic add_i,
  input wire logic [pmc_pkg::INFO_W-1:0] info_i,
  input wire logic numeric_i,
  output logic [pmc_pkg::CSUM_W-1:0] csum_o
);
  logic [pmc_pkg::CSUM_W-1:0] sum_q;
  logic [pmc_pkg::CSUM_W-1:0] groups;
  logic [pmc_pkg::NUM_CSUM_W-1:0] fold;

  // Only the low eight bits ever matter, so the sum wraps freely.
  assign groups = info_i[7:0] + info_i[15:8] + {3'h0, info_i[20:16]};

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      sum_q <= '0;
    end else if (add_i) begin
      sum_q <= sum_q + groups;
    end
  end

  assign fold = sum_q[pmc_pkg::NUM_CSUM_W-1:0]
              + {4'h0, sum_q[pmc_pkg::CSUM_W-1:pmc_pkg::FOLD_SHIFT]};
  assign csum_o = numeric_i ? {2'h0, ~fold} : ~sum_q;

  a_sum_adds: assert property (@(posedge clk_i) disable iff (rst_i)
    add_i && !clr_i |=> sum_q == $past(sum_q) + $past(groups))
    else $error("checksum sum did not add the codeword groups");
  a_sum_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_i |=> sum_q == 8'h00)
    else $error("checksum sum not cleared at fragment start");
endmodule // pmc_csum

/* File: hw/pmc_null_strip.sv */
// Drops null characters: trailing ones as fill, embedded ones as channel errors.
// Assumes flush_i at the end of each fragment, after its last character.
module pmc_null_strip (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic ch_valid_i,
  input wire logic [pmc_pkg::CHAR_W-1:0] ch_i,
  output logic out_valid_o,
  output logic [pmc_pkg::CHAR_W-1:0] out_o,
  output logic err_o
);
  logic [7:0] pend_q;
  logic is_nul;

  assign is_nul = ch_i == pmc_pkg::CHAR_NUL;

  // A null is held back until we know whether a real character follows.
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      pend_q <= '0;
    end else if (ch_valid_i && is_nul) begin
      pend_q <= (pend_q == 8'hff) ? pend_q : pend_q + 8'h01;
    end else if (ch_valid_i) begin
      pend_q <= '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_o <= '0;
      err_o <= 1'b0;
    end else begin
      out_valid_o <= ch_valid_i && !is_nul;
      err_o <= ch_valid_i && !is_nul && pend_q != 8'h00 && !flush_i;
      if (ch_valid_i && !is_nul) begin
        out_o <= ch_i;
      end
    end
  end

  a_no_nul_out: assert property (@(posedge clk_i) disable iff (rst_i)
    out_valid_o |-> out_o != 7'h00)
    else $error("null character passed to output");
  a_stray_nul: assert property (@(posedge clk_i) disable iff (rst_i)
    ch_valid_i && is_nul && !flush_i ##1 ch_valid_i && !is_nul && !flush_i |=> err_o)
    else $error("embedded null not reported");
endmodule // pmc_null_strip

/* File: test/pmc_tx_model.sv */
// Transmitter model: offers one fragment header, then the fragment's codewords.
// Assumes the block's ready outputs are sampled at the rising clock edge.
module pmc_tx_model (
  input wire logic clk_i,
  input wire logic hdr_ready_i,
  input wire logic cw_ready_i,
  output logic hdr_valid_o,
  output pmc_pkg::pmc_hdr_t hdr_o,
  output logic cw_valid_o,
  output logic [pmc_pkg::INFO_W-1:0] cw_info_o,
  output logic cw_last_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hdr_valid_o = 1'b0;
    hdr_o = '0;
    cw_valid_o = 1'b0;
    cw_info_o = '0;
    cw_last_o = 1'b0;
  end

  // Released header lines carry the inverse of the last value; word lines carry it too, then toggle back to the last value on every other stall cycle.
  task automatic send(input pmc_pkg::pmc_hdr_t h, input logic [pmc_pkg::INFO_W-1:0] w[8],
                      input int n, input int stall);
    @(posedge clk_i);
    hdr_valid_o <= 1'b1;
    hdr_o <= h;
    do @(posedge clk_i); while (hdr_ready_i !== 1'b1);
    hdr_valid_o <= 1'b0;
    hdr_o <= ~h;
    for (int i = 0; i < n; i++) begin
      repeat (stall) begin
        @(posedge clk_i);
        cw_info_o <= ~cw_info_o;
      end
      @(posedge clk_i);
      cw_valid_o <= 1'b1;
      cw_info_o <= w[i];
      cw_last_o <= (i == n - 1);
      do @(posedge clk_i); while (cw_ready_i !== 1'b1);
      cw_valid_o <= 1'b0;
      cw_info_o <= ~w[i];
      cw_last_o <= 1'b0;
    end
  endtask
endmodule // pmc_tx_model

/* File: test/tb_top.sv */
// Self-checking bench of the paging message checker with a reference model.
// Assumes the transmitter model file is compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, hdr_valid, hdr_ready, cw_valid, cw_last, cw_ready;
  logic char_valid_o, char_aligned_o, irq_o;
  logic [1:0] char_mode_o;
  logic [pmc_pkg::CHAR_W-1:0] char_o;
  logic [pmc_pkg::INFO_W-1:0] cw_info;
  pmc_pkg::pmc_hdr_t hdr;
  pmc_pkg::pmc_res_t res_o, res_cap;
  logic res_seen = 1'b0;
  logic [pmc_pkg::INFO_W-1:0] w[8];
  logic [6:0] got[$];
  logic [6:0] exp_q[$];
  int n, checked = 0, miscompares = 0, cycles = 0;
  logic [31:0] q;

  initial forever #12.5 clk_i = ~clk_i;

  pmc_tx_model tx (.clk_i(clk_i), .hdr_ready_i(hdr_ready), .cw_ready_i(cw_ready),
    .hdr_valid_o(hdr_valid), .hdr_o(hdr), .cw_valid_o(cw_valid), .cw_info_o(cw_info),
    .cw_last_o(cw_last));

  pmc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .hdr_valid_i(hdr_valid), .hdr_i(hdr), .hdr_ready_o(hdr_ready), .cw_valid_i(cw_valid),
    .cw_info_i(cw_info), .cw_last_i(cw_last), .cw_ready_o(cw_ready),
    .char_valid_o(char_valid_o), .char_o(char_o), .char_mode_o(char_mode_o),
    .char_aligned_o(char_aligned_o), .res_o(res_o), .irq_o(irq_o));

  always @(posedge clk_i) begin
    if (char_valid_o === 1'b1) got.push_back(char_o);
    if (res_o.valid === 1'b1) begin
      res_cap <= res_o;
      res_seen <= 1'b1;
    end
  end

  task automatic tally_and_finish();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic fillw(input logic [1:0] mt);
    for (int i = 0; i < n; i++) begin
      w[i] = pmc_pkg::INFO_W'($urandom);
      if (mt == pmc_pkg::MT_ALNUM) begin
        w[i] = {7'($urandom_range(127, 1)), 7'($urandom_range(127, 1)),
                7'($urandom_range(127, 1))};
      end
    end
  endtask

  // Sends one fragment of w[0..n-1] and checks result, characters, mode and status.
  task automatic frag(input logic [1:0] mt, sl, input logic [5:0] num, input logic [1:0] fn, cm,
                      input logic ret, cont, bad, input logic [4:0] ex, input logic [1:0] mx);
    int sum;
    logic [7:0] s8, c;
    logic [6:0] f, ch;
    logic nul, err;
    pmc_pkg::pmc_hdr_t h;
    sum = 0;
    nul = 1'b0;
    err = 1'b0;
    exp_q.delete();
    got.delete();
    for (int i = 0; i < n; i++) begin
      sum += w[i][7:0] + w[i][15:8] + w[i][20:16];
      for (int j = 0; j < 3 && mt == pmc_pkg::MT_ALNUM; j++) begin
        ch = w[i][7*j +: 7];
        if (ch == pmc_pkg::CHAR_NUL) nul = 1'b1;
        else begin
          err |= nul;
          exp_q.push_back(ch);
        end
      end
    end
    s8 = sum[7:0];
    f = s8[5:0] + s8[7:6];
    c = (mt == pmc_pkg::MT_NUMERIC) ? {2'h0, ~f[5:0]} : ~s8;
    h = '0;
    h.msg_type = mt;
    h.addr_slot = sl;
    h.msg_num = num;
    h.frag_num = fn;
    h.char_mode = cm;
    h.retrieve = ret;
    h.cont = cont;
    h.rx_csum = bad ? c ^ 8'h01 : c;
    res_seen = 1'b0;
    tx.send(h, w, n, $urandom_range(3));
    for (int k = 0; k < 300 && res_seen !== 1'b1; k++) @(posedge clk_i);
    chk(res_cap.calc, c);
    chk(res_cap.ok, !bad);
    chk(got.size(), exp_q.size());
    foreach (exp_q[i]) chk(got[i], exp_q[i]);
    chk(char_mode_o, mx);
    chk(char_aligned_o, mx != pmc_pkg::CM_NO_EF);
    ex = ex | 5'h10 | (bad ? 5'h01 : 5'h00) | (err ? 5'h08 : 5'h00);
    wb(1'b0, pmc_pkg::ADR_STAT, 32'h0);
    chk(q[4:0], ex);
    chk(irq_o, ex[pmc_pkg::ST_CSUM]);
    wb(1'b0, pmc_pkg::ADR_INFO, 32'h0);
    chk(q[17:0], {mx, c, 2'h0, num});
    wb(1'b1, pmc_pkg::ADR_STAT, 32'h1f);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
  endtask

  initial begin
    void'($urandom(32'he3638aae));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(hdr_ready, 1'b1);
    chk(char_mode_o, pmc_pkg::CM_DEFAULT);
    wb(1'b1, pmc_pkg::ADR_CTRL, 32'hffffffff);
    wb(1'b0, pmc_pkg::ADR_CTRL, 32'h0);
    chk(q, pmc_pkg::CTRL_RST);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, pmc_pkg::ADR_MASK, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, pmc_pkg::ADR_MASK, 32'h1);
    for (int t = 0; t < 8; t++) begin
      n = $urandom_range(4, 1);
      fillw(2'(t));
      frag(2'(t), 2'(t), 6'(t), pmc_pkg::FRAG_FIRST, 2'($urandom), 1'b0, 1'b0, t >= 4, 5'h0,
           pmc_pkg::CM_DEFAULT);
    end
    n = 2;
    // A null in mid-fragment, then end-of-text and null padding at the end.
    w[0] = {7'h41, 7'h00, 7'h42};
    w[1] = {7'h00, 7'h00, 7'h03};
    frag(pmc_pkg::MT_ALNUM, 2'h0, 6'h09, 2'h3, 2'h3, 1'b0, 1'b0, 1'b0, 5'h0, 2'h2);
    n = 1;
    w[0] = {7'h00, 7'h00, 7'h43};
    frag(pmc_pkg::MT_ALNUM, 2'h0, 6'h0a, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 5'h0, 2'h2);
    // Numbering on one address with roll-over after 7.
    wb(1'b1, pmc_pkg::ADR_CTRL, 32'h0701);
    frag(pmc_pkg::MT_HEX, 2'h1, 6'h06, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 5'h00, 2'h2);
    frag(pmc_pkg::MT_HEX, 2'h1, 6'h07, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 5'h00, 2'h2);
    frag(pmc_pkg::MT_HEX, 2'h1, 6'h00, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 5'h00, 2'h2);
    frag(pmc_pkg::MT_HEX, 2'h1, 6'h02, 2'h3, 2'h2, 1'b1, 1'b0, 1'b0, 5'h02, 2'h2);
    frag(pmc_pkg::MT_HEX, 2'h1, 6'h05, 2'h3, 2'h2, 1'b0, 1'b0, 1'b0, 5'h00, 2'h2);
    wb(1'b1, pmc_pkg::ADR_CTRL, 32'h3f01);
    // Fragments 3, 0 then 2: the skipped 1 must be seen.
    fillw(pmc_pkg::MT_ALNUM);
    frag(pmc_pkg::MT_ALNUM, 2'h2, 6'h14, 2'h3, 2'h3, 1'b0, 1'b1, 1'b0, 5'h00, 2'h2);
    frag(pmc_pkg::MT_ALNUM, 2'h2, 6'h14, 2'h0, 2'h3, 1'b0, 1'b1, 1'b0, 5'h00, 2'h3);
    frag(pmc_pkg::MT_ALNUM, 2'h2, 6'h14, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 5'h04, 2'h0);
    // A reserved mode code on a follow-on fragment passes through and stays aligned.
    frag(pmc_pkg::MT_ALNUM, 2'h2, 6'h15, 2'h3, 2'h1, 1'b0, 1'b1, 1'b0, 5'h00, 2'h2);
    frag(pmc_pkg::MT_ALNUM, 2'h2, 6'h15, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0, 5'h00, 2'h1);
    wb(1'b1, pmc_pkg::ADR_CTRL, 32'h0);
    @(posedge clk_i);
    chk(hdr_ready, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
